/* File: meter_pkg.sv */
package meter_pkg;

	// register bus geometry
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;

	// register offsets
	localparam logic [15:0] GAIN_ADJUST_WORD_OFS  = 16'h002e;
	localparam logic [15:0] EXTERNAL_TEMP_SELECT_OFS  = 16'h0038;
	localparam logic [15:0] LIN_COEFF_OFS = 16'h0039;
	localparam logic [15:0] QUAD_COEFF_OFS = 16'h003a;
	localparam logic [15:0] REF_TEMP_OFS  = 16'h003b;
	localparam logic [15:0] TRIM_SEL_OFS  = 16'h20fd;
	localparam logic [15:0] TRIM_VAL_OFS  = 16'h20ff;
	localparam logic [15:0] CTRL_OFS      = 16'h2100;
	localparam logic [15:0] CHOP_OFS      = 16'h2101;
	localparam logic [15:0] STATUS_OFS    = 16'h2102;

	// control register field positions
	localparam int CONV_OFF_BIT   = 0;
	localparam int CKOUT_OFF_BIT  = 1;
	localparam int EMU_OFF_BIT    = 2;
	localparam int FLASH_SHORT_BIT = 3;
	localparam int BOOST_EN_BIT   = 4;
	localparam int CE_EN_BIT      = 5;
	localparam int MON_EN_BIT     = 6;
	localparam int DIV_LSB        = 8;
	localparam int DIV_W          = 3;
	localparam int CTRL_W         = 11;

	// status register field positions
	localparam int WDOG_BIT    = 0;
	localparam int CHOP_BIT    = 1;
	localparam int PREBOOT_BIT = 2;
	localparam int RUN_BIT     = 3;

	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;
	localparam logic [1:0]        CHOP_RESET = 2'h0;
	localparam logic [7:0]        TRIM_SEL_RESET = 8'h00;
	localparam logic [31:0]       WORD_RESET = 32'h0000_0000;

	// encodings
	localparam logic [31:0] EXT_INTERNAL = 32'h0000_0000;
	localparam logic [31:0] EXT_EXTERNAL = 32'h0000_000f;
	localparam logic [7:0]  TRIM_SEL_MAG = 8'h04;
	localparam logic [7:0]  TRIM_SEL_A   = 8'h05;
	localparam logic [7:0]  TRIM_SEL_B   = 8'h06;
	localparam logic [1:0]  CHOP_POS     = 2'h1;
	localparam logic [1:0]  CHOP_REV     = 2'h2;

	// timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int RESET_WAIT_OSC  = 4100;
	localparam int PREBOOT_CYC     = 32;
	localparam int FLASH_SHORT_NS  = 33;
	localparam int FLASH_LONG_NS   = 66;
	localparam logic [3:0] FLASH_SHORT_CYC = 4'((FLASH_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] FLASH_LONG_CYC  = 4'((FLASH_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef enum {SEQ_HOLD, SEQ_WAIT, SEQ_PREBOOT, SEQ_RUN} seq_e;

	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_s;

	typedef struct packed {
		logic [7:0] trimA;
		logic [7:0] trimB;
		logic [2:0] mag;
	} fuse_s;

endpackage

/* File: meter_power_trim_chop_ctrl.sv */
// Notes on behaviour
// - supply below bias threshold holds processor in reset, digital logic stopped
// - supply above threshold starts timer; processor released after 4100 oscillator cycles
// - after release the processor runs a 32 cycle preboot phase
// - battery domain keeps oscillator, clock, external RAM and watchdog flag
// - converter, clock test output or emulator clock off bits shut that resource
// - flash short pulse bit shortens flash read pulse to 33 ns
// - display boost, compute engine, monitor output enables at 0 turn them off
// - processor clock divided by divider field; larger value gives slower clock
// - emulator clock off blocks all emulator port access including flash work
// - firmware writes 4, 5 or 6 to trim select, reads fuse from trim value
// - external temp select 0: engine computes gain adjust from coefficients
// - external temp select 15: engine uses firmware written gain adjust word
// - chop signal high swaps amplifier inputs, low keeps positive connection
// - chop bits 01 force positive, 10 force reversed, equal bits toggle
// - chop bits 00 or 11 invert chop signal every multiplexer cycle
// - reset mode clears all configuration bits; oscillator keeps running; here only control, chop and trim select clear, the engine words are kept
// - chop value written between cycles governs the whole next multiplexer cycle
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
module meter_power_trim_chop_ctrl #(
	parameter int unsigned RESET_WAIT_CYC = meter_pkg::RESET_WAIT_OSC
) (
	input  wire logic               clk,
	input  wire logic               arst_n,
	input  wire logic               supplySenseInput,
	input  wire logic               resetPin_n,
	input  wire meter_pkg::fuse_s   fuses,
	input  wire meter_pkg::bus_req_s busReq,
	input  wire logic               muxCycleEnd,
	input  wire logic [15:0]        tempMeasured,
	input  wire logic               watchdogOverflow,
	output logic [31:0]             rdata,
	output logic                    processorReset_n,
	output logic                    preboot,
	output logic                    converterEnable,
	output logic                    clockTestEnable,
	output logic                    emulatorClockEnable,
	output logic                    emulatorAccessEnable,
	output logic [3:0]              readPulseCycles,
	output logic                    displayBoostEnable,
	output logic                    ceEnable,
	output logic                    monitorOutputEnable,
	output logic                    procClkEn,
	output logic                    chopSignal,
	output logic [31:0]             gainAdjust,
	output logic                    watchdogOverflowFlag
);
	import meter_pkg::*;

	localparam int WAIT_W = $clog2(RESET_WAIT_CYC + 1);

	// fuse group lookup; other selects read as zero
	function automatic logic [7:0] trimLookup(input logic [7:0] sel, input fuse_s f);
		if (sel == TRIM_SEL_MAG) begin
			return {5'h00, f.mag};
		end else if (sel == TRIM_SEL_A) begin
			return f.trimA;
		end else if (sel == TRIM_SEL_B) begin
			return f.trimB;
		end
		return 8'h00;
	endfunction

	// pins and fuses cross in through two flip-flops each
	logic  [1:0] supplyMeta, supplySync;
	fuse_s       fuseMeta, fuseSync;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			supplyMeta <= 2'h0;
			supplySync <= 2'h0;
			fuseMeta   <= '0;
			fuseSync   <= '0;
		end else begin
			supplyMeta <= {supplySenseInput, resetPin_n};
			supplySync <= supplyMeta;
			fuseMeta   <= fuses;
			fuseSync   <= fuseMeta;
		end
	end

	logic supplyGood;
	assign supplyGood = supplySync[1] & supplySync[0];

	// reset sequencer: hold, wait timer, preboot, run
	seq_e              seqState, next_seqState;
	logic [WAIT_W-1:0] waitCnt, next_waitCnt;
	logic [5:0]        prebootCnt, next_prebootCnt;
	always_comb begin
		next_seqState   = seqState;
		next_waitCnt    = waitCnt;
		next_prebootCnt = prebootCnt;
		if (!supplyGood) begin
			next_seqState = SEQ_HOLD;
		end else begin
			case (seqState)
				SEQ_HOLD: begin
					next_seqState = SEQ_WAIT;
					next_waitCnt  = '0;
				end
				SEQ_WAIT: begin
					if (waitCnt == WAIT_W'(RESET_WAIT_CYC - 1)) begin
						next_seqState   = SEQ_PREBOOT;
						next_prebootCnt = 6'h00;
					end else begin
						next_waitCnt = waitCnt + 1'b1;
					end
				end
				SEQ_PREBOOT: begin
					if (prebootCnt == 6'(PREBOOT_CYC - 1)) begin
						next_seqState = SEQ_RUN;
					end else begin
						next_prebootCnt = prebootCnt + 6'h01;
					end
				end
				default: next_seqState = SEQ_RUN;
			endcase
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seqState   <= SEQ_HOLD;
			waitCnt    <= '0;
			prebootCnt <= 6'h00;
		end else begin
			seqState   <= next_seqState;
			waitCnt    <= next_waitCnt;
			prebootCnt <= next_prebootCnt;
		end
	end

	logic running;
	assign running = (seqState == SEQ_PREBOOT) || (seqState == SEQ_RUN);

	// software registers; writes are ignored while the processor is held
	logic [CTRL_W-1:0] ctrl, next_ctrl;
	logic [1:0]        chopCtrl, next_chopCtrl;
	logic [7:0]        trim_fuse_select, next_trim_fuse_select;
	logic [31:0]       extTemp, next_extTemp, linCoeff, next_linCoeff;
	logic [31:0]       quadCoeff, next_quadCoeff, refTemp, next_refTemp;
	logic [31:0]       next_gainAdjust;
	logic              next_wdogFlag;
	logic              wrEn;
	logic signed [15:0] dT;
	logic signed [31:0] dTsq, linTerm, quadTerm;
	assign wrEn     = busReq.wr && running;
	assign dT       = $signed(tempMeasured - refTemp[15:0]);
	assign dTsq     = dT * dT;
	assign linTerm  = $signed(linCoeff[15:0]) * dT;
	assign quadTerm = $signed(quadCoeff[15:0]) * $signed(dTsq[31:16]);
	always_comb begin
		next_ctrl       = ctrl;
		next_chopCtrl   = chopCtrl;
		next_trim_fuse_select    = trim_fuse_select;
		next_extTemp    = extTemp;
		next_linCoeff   = linCoeff;
		next_quadCoeff  = quadCoeff;
		next_refTemp    = refTemp;
		next_gainAdjust = gainAdjust;
		next_wdogFlag   = watchdogOverflowFlag;
		if (seqState == SEQ_HOLD) begin
			next_ctrl     = CTRL_RESET;
			next_chopCtrl = CHOP_RESET;
			next_trim_fuse_select  = TRIM_SEL_RESET;
		end else if (wrEn) begin
			if (busReq.addr == CTRL_OFS) begin
				next_ctrl = busReq.wdata[CTRL_W-1:0];
			end else if (busReq.addr == CHOP_OFS) begin
				next_chopCtrl = busReq.wdata[1:0];
			end else if (busReq.addr == TRIM_SEL_OFS) begin
				next_trim_fuse_select = busReq.wdata[7:0];
			end else if (busReq.addr == EXTERNAL_TEMP_SELECT_OFS) begin
				next_extTemp = busReq.wdata;
			end else if (busReq.addr == LIN_COEFF_OFS) begin
				next_linCoeff = busReq.wdata;
			end else if (busReq.addr == QUAD_COEFF_OFS) begin
				next_quadCoeff = busReq.wdata;
			end else if (busReq.addr == REF_TEMP_OFS) begin
				next_refTemp = busReq.wdata;
			end else if (busReq.addr == GAIN_ADJUST_WORD_OFS && extTemp != EXT_INTERNAL) begin
				next_gainAdjust = busReq.wdata;
			end else if (busReq.addr == STATUS_OFS && busReq.wdata[WDOG_BIT]) begin
				next_wdogFlag = 1'b0;
			end
		end
		// engine owns the word in internal mode, once per multiplexer cycle
		if (extTemp == EXT_INTERNAL && ctrl[CE_EN_BIT] && muxCycleEnd && running) begin
			next_gainAdjust = linTerm + (quadTerm >>> 8);
		end
		// a new overflow beats a simultaneous clear
		if (watchdogOverflow) begin
			next_wdogFlag = 1'b1;
		end
	end
	// the watchdog flag sits in the battery domain: a supply drop leaves it alone
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl                 <= CTRL_RESET;
			chopCtrl             <= CHOP_RESET;
			trim_fuse_select              <= TRIM_SEL_RESET;
			extTemp              <= WORD_RESET;
			linCoeff             <= WORD_RESET;
			quadCoeff            <= WORD_RESET;
			refTemp              <= WORD_RESET;
			gainAdjust           <= WORD_RESET;
			watchdogOverflowFlag <= 1'b0;
		end else begin
			ctrl                 <= next_ctrl;
			chopCtrl             <= next_chopCtrl;
			trim_fuse_select              <= next_trim_fuse_select;
			extTemp              <= next_extTemp;
			linCoeff             <= next_linCoeff;
			quadCoeff            <= next_quadCoeff;
			refTemp              <= next_refTemp;
			gainAdjust           <= next_gainAdjust;
			watchdogOverflowFlag <= next_wdogFlag;
		end
	end

	// read mux; data stand one cycle after the strobe and are zero otherwise
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (busReq.rd) begin
			if (busReq.addr == CTRL_OFS) begin
				next_rdata = {21'h000000, ctrl};
			end else if (busReq.addr == CHOP_OFS) begin
				next_rdata = {30'h00000000, chopCtrl};
			end else if (busReq.addr == TRIM_SEL_OFS) begin
				next_rdata = {24'h000000, trim_fuse_select};
			end else if (busReq.addr == TRIM_VAL_OFS) begin
				next_rdata = {24'h000000, trimLookup(trim_fuse_select, fuseSync)};
			end else if (busReq.addr == EXTERNAL_TEMP_SELECT_OFS) begin
				next_rdata = extTemp;
			end else if (busReq.addr == LIN_COEFF_OFS) begin
				next_rdata = linCoeff;
			end else if (busReq.addr == QUAD_COEFF_OFS) begin
				next_rdata = quadCoeff;
			end else if (busReq.addr == REF_TEMP_OFS) begin
				next_rdata = refTemp;
			end else if (busReq.addr == GAIN_ADJUST_WORD_OFS) begin
				next_rdata = gainAdjust;
			end else if (busReq.addr == STATUS_OFS) begin
				next_rdata = {28'h0000000, seqState == SEQ_RUN, preboot, chopSignal,
					watchdogOverflowFlag};
			end
		end
	end

	// chop polarity changes only at a cycle boundary, so a mid-cycle write waits
	logic next_chopSignal;
	always_comb begin
		next_chopSignal = chopSignal;
		if (muxCycleEnd && running) begin
			if (chopCtrl == CHOP_POS) begin
				next_chopSignal = 1'b0;
			end else if (chopCtrl == CHOP_REV) begin
				next_chopSignal = 1'b1;
			end else begin
				next_chopSignal = !chopSignal;
			end
		end
	end

	// processor clock enable: one pulse every divider+1 cycles
	logic [DIV_W-1:0] divCnt, next_divCnt;
	logic [DIV_W-1:0] divSet;
	logic             next_procClkEn;
	assign divSet = ctrl[DIV_LSB +: DIV_W];
	always_comb begin
		next_divCnt    = (divCnt >= divSet) ? '0 : divCnt + 1'b1;
		next_procClkEn = running && (divCnt >= divSet);
		if (!running) begin
			next_divCnt = '0;
		end
	end

	// resource gating, all outputs from flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata                <= 32'h0000_0000;
			chopSignal           <= 1'b0;
			divCnt               <= '0;
			procClkEn            <= 1'b0;
			processorReset_n     <= 1'b0;
			preboot              <= 1'b0;
			converterEnable      <= 1'b0;
			clockTestEnable      <= 1'b0;
			emulatorClockEnable  <= 1'b0;
			emulatorAccessEnable <= 1'b0;
			readPulseCycles      <= FLASH_LONG_CYC;
			displayBoostEnable   <= 1'b0;
			ceEnable             <= 1'b0;
			monitorOutputEnable  <= 1'b0;
		end else begin
			rdata                <= next_rdata;
			chopSignal           <= next_chopSignal;
			divCnt               <= next_divCnt;
			procClkEn            <= next_procClkEn;
			processorReset_n     <= running;
			preboot              <= (seqState == SEQ_PREBOOT);
			converterEnable      <= running && !ctrl[CONV_OFF_BIT];
			clockTestEnable      <= running && !ctrl[CKOUT_OFF_BIT];
			emulatorClockEnable  <= running && !ctrl[EMU_OFF_BIT];
			emulatorAccessEnable <= (seqState == SEQ_RUN) && !ctrl[EMU_OFF_BIT];
			readPulseCycles      <= ctrl[FLASH_SHORT_BIT] ? FLASH_SHORT_CYC : FLASH_LONG_CYC;
			displayBoostEnable   <= running && ctrl[BOOST_EN_BIT];
			ceEnable             <= running && ctrl[CE_EN_BIT];
			monitorOutputEnable  <= running && ctrl[MON_EN_BIT];
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	property p_hold;
		seqState == SEQ_HOLD |=> !processorReset_n && !converterEnable;
	endproperty
	a_hold: assert property (p_hold) else $error("processor left reset while supply low");

	property p_wait;
		seqState == SEQ_WAIT && next_seqState == SEQ_PREBOOT |-> waitCnt == WAIT_W'(RESET_WAIT_CYC - 1);
	endproperty
	a_wait: assert property (p_wait) else $error("reset timer released early or late");

	property p_preboot;
		$fell(preboot) && processorReset_n |-> $past(preboot, 32) && !$past(preboot, 33);
	endproperty
	a_preboot: assert property (p_preboot) else $error("preboot phase not 32 cycles");

	property p_convOff;
		wrEn && busReq.addr == CTRL_OFS && busReq.wdata[CONV_OFF_BIT] |-> ##2 !converterEnable;
	endproperty
	a_convOff: assert property (p_convOff) else $error("converter not shut off");

	property p_flash;
		ctrl[FLASH_SHORT_BIT] |=> readPulseCycles == FLASH_SHORT_CYC;
	endproperty
	a_flash: assert property (p_flash) else $error("flash pulse not shortened");

	property p_boost;
		wrEn && busReq.addr == CTRL_OFS && !busReq.wdata[BOOST_EN_BIT] |-> ##2 !displayBoostEnable;
	endproperty
	a_boost: assert property (p_boost) else $error("display boost still on");

	property p_div;
		procClkEn && $past(procClkEn) |-> $past(divSet, 2) == '0 || $past(divSet) == '0;
	endproperty
	a_div: assert property (p_div) else $error("processor clock not divided");

	property p_emu;
		emulatorAccessEnable |-> !$past(ctrl[EMU_OFF_BIT]) && $past(seqState) == SEQ_RUN;
	endproperty
	a_emu: assert property (p_emu) else $error("emulator access while disabled");

	property p_trimZero;
		busReq.rd && busReq.addr == TRIM_VAL_OFS && (trim_fuse_select < TRIM_SEL_MAG || trim_fuse_select > TRIM_SEL_B)
			|=> rdata == 32'h0000_0000;
	endproperty
	a_trimZero: assert property (p_trimZero) else $error("trim value not zero");

	property p_extGain;
		extTemp == EXT_EXTERNAL && !(wrEn && busReq.addr == GAIN_ADJUST_WORD_OFS) |=> $stable(gainAdjust);
	endproperty
	a_extGain: assert property (p_extGain) else $error("engine changed external gain");

	property p_chopAuto;
		muxCycleEnd && running && chopCtrl[1] == chopCtrl[0] |=> chopSignal != $past(chopSignal);
	endproperty
	a_chopAuto: assert property (p_chopAuto) else $error("chop did not toggle");

	property p_chopForce;
		muxCycleEnd && running && chopCtrl == CHOP_POS |=> !chopSignal;
	endproperty
	a_chopForce: assert property (p_chopForce) else $error("chop not forced positive");

	// polarity may only move at a cycle boundary, never mid-cycle
	property p_chopHold;
		!(muxCycleEnd && running) |=> $stable(chopSignal);
	endproperty
	a_chopHold: assert property (p_chopHold) else $error("chop changed mid-cycle");

	property p_clearCfg;
		seqState == SEQ_HOLD |=> ctrl == CTRL_RESET && chopCtrl == CHOP_RESET;
	endproperty
	a_clearCfg: assert property (p_clearCfg) else $error("config not cleared in reset");

	c_run:   cover property ($rose(seqState == SEQ_RUN));
	c_chop:  cover property (muxCycleEnd && chopCtrl == 2'h3 ##[1:20] muxCycleEnd);
	c_trim:  cover property (busReq.rd && busReq.addr == TRIM_VAL_OFS && trim_fuse_select == TRIM_SEL_A);
	c_gain:  cover property (extTemp == EXT_INTERNAL && ceEnable && muxCycleEnd);

endmodule // meter_power_trim_chop_ctrl

/* File: testbench.sv */
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("unexpected at %0t: %s got %0h exp %0h", $time, msg, got, exp); end end
module testbench;
	import meter_pkg::*;
	// short reset wait keeps the power-up scenario quick
	localparam int WAIT = 8;
	logic                clk;
	logic                arst_n;
	logic                supplySenseInput;
	logic                resetPin_n;
	fuse_s               fuses;
	bus_req_s            busReq;
	logic                muxCycleEnd;
	logic [15:0]         tempMeasured;
	logic                watchdogOverflow;
	logic [31:0]         rdata;
	logic                processorReset_n;
	logic                preboot;
	logic                converterEnable;
	logic                clockTestEnable;
	logic                emulatorClockEnable;
	logic                emulatorAccessEnable;
	logic [3:0]          readPulseCycles;
	logic                displayBoostEnable;
	logic                ceEnable;
	logic                monitorOutputEnable;
	logic                procClkEn;
	logic                chopSignal;
	logic [31:0]         gainAdjust;
	logic                watchdogOverflowFlag;
	int                  fail_count;
	int                  n_checks;
	int                  cycles;
	int                  n;
	int                  pb;
	logic [31:0]         d;
	logic [10:0]         cv[4] = '{11'h000, 11'h07f, 11'h015, 11'h06a};
	logic [7:0]          sel[5] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h00};
	logic [7:0]          tv[5] = '{8'h06, 8'ha5, 8'h3c, 8'h00, 8'h00};
	int                  dv[3] = '{0, 3, 7};
	// quadratic term is small but nonzero for a 0x200 temperature step
	localparam int DELTA_T  = 32'sh0300 - 32'sh0100;
	localparam int GAIN_EXP = 100 * DELTA_T + ((256 * ((DELTA_T * DELTA_T) >>> 16)) >>> 8);

	meter_power_trim_chop_ctrl #(.RESET_WAIT_CYC(WAIT)) dut (
		.clk                  (clk),
		.arst_n               (arst_n),
		.supplySenseInput     (supplySenseInput),
		.resetPin_n           (resetPin_n),
		.fuses                (fuses),
		.busReq               (busReq),
		.muxCycleEnd          (muxCycleEnd),
		.tempMeasured         (tempMeasured),
		.watchdogOverflow     (watchdogOverflow),
		.rdata                (rdata),
		.processorReset_n     (processorReset_n),
		.preboot              (preboot),
		.converterEnable      (converterEnable),
		.clockTestEnable      (clockTestEnable),
		.emulatorClockEnable  (emulatorClockEnable),
		.emulatorAccessEnable (emulatorAccessEnable),
		.readPulseCycles      (readPulseCycles),
		.displayBoostEnable   (displayBoostEnable),
		.ceEnable             (ceEnable),
		.monitorOutputEnable  (monitorOutputEnable),
		.procClkEn            (procClkEn),
		.chopSignal           (chopSignal),
		.gainAdjust           (gainAdjust),
		.watchdogOverflowFlag (watchdogOverflowFlag)
	);

	// free-running clock, 10 ns period
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// every drive task starts on an edge and returns 1 ns after its last edge
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] v);
		@(posedge clk);
		busReq <= '{a, v, 1'b1, 1'b0};
		@(posedge clk);
		busReq <= '0;
		#1;
	endtask
	// read data stand only in the cycle after the strobe, so grab them there
	task automatic rd(input logic [15:0] a, output logic [31:0] v);
		@(posedge clk);
		busReq <= '{a, 32'h0000_0000, 1'b0, 1'b1};
		@(posedge clk);
		busReq <= '0;
		#1;
		v = rdata;
	endtask
	task automatic pulseMux();
		@(posedge clk);
		muxCycleEnd <= 1'b1;
		@(posedge clk);
		muxCycleEnd <= 1'b0;
		cyc(1);
	endtask
	// watches release and the preboot span over a fixed window after power good
	task automatic powerUp();
		@(posedge clk);
		supplySenseInput <= 1'b1;
		n = 0;
		pb = 0;
		for (int i = 1; i <= 80; i++) begin
			cyc(1);
			if (preboot === 1'b1) pb++;
			if (processorReset_n !== 1'b1) n = i;
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// hang guard, far above the few hundred cycles the sequence needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			$display("unexpected at %0t: timeout", $time);
			conclude();
		end
	end

	initial begin
		arst_n = 1'b0;
		supplySenseInput = 1'b0;
		resetPin_n = 1'b1;
		fuses = '{8'ha5, 8'h3c, 3'h6};
		busReq = '0;
		muxCycleEnd = 1'b0;
		tempMeasured = 16'h0300;
		watchdogOverflow = 1'b0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		cyc(20);
		`CHK(processorReset_n, 1'b0, "reset held")
		`CHK(readPulseCycles, FLASH_LONG_CYC, "pulse at reset")
		wr(CTRL_OFS, 32'h0000_007f);
		powerUp();
		`CHK(n >= WAIT && n <= WAIT + 6, 1'b1, "release delay")
		`CHK(pb, 32, "preboot length")
		rd(CTRL_OFS, d);
		`CHK(d, 32'h0000_0000, "write in reset")
		rd(STATUS_OFS, d);
		`CHK(d[RUN_BIT], 1'b1, "run status")
		// resource gating, one control word per row
		for (int i = 0; i < 4; i++) begin
			wr(CTRL_OFS, {21'h0, cv[i]});
			cyc(1);
			`CHK(converterEnable, ~cv[i][CONV_OFF_BIT], "converter")
			`CHK(clockTestEnable, ~cv[i][CKOUT_OFF_BIT], "clock test")
			`CHK(emulatorClockEnable, ~cv[i][EMU_OFF_BIT], "emu clock")
			`CHK(emulatorAccessEnable, ~cv[i][EMU_OFF_BIT], "emu access")
			`CHK(readPulseCycles, cv[i][3] ? FLASH_SHORT_CYC : FLASH_LONG_CYC, "pulse")
			`CHK(displayBoostEnable, cv[i][BOOST_EN_BIT], "boost")
			`CHK(ceEnable, cv[i][CE_EN_BIT], "engine")
			`CHK(monitorOutputEnable, cv[i][MON_EN_BIT], "monitor")
			rd(CTRL_OFS, d);
			`CHK(d, {21'h0, cv[i]}, "ctrl readback")
		end
		// third gap is measured so a divider change mid-count cannot skew it
		for (int i = 0; i < 3; i++) begin
			wr(CTRL_OFS, 32'(dv[i]) << DIV_LSB);
			for (int j = 0; j < 3; j++) begin
				n = 0;
				do begin
					cyc(1);
					n++;
				end while (procClkEn !== 1'b1 && n < 20);
			end
			`CHK(n, dv[i] + 1, "divider period")
		end
		for (int i = 0; i < 5; i++) begin
			wr(TRIM_SEL_OFS, {24'h0, sel[i]});
			rd(TRIM_VAL_OFS, d);
			`CHK(d, {24'h0, tv[i]}, "trim value")
		end
		rd(16'h1234, d);
		`CHK(d, 32'h0000_0000, "unmapped read")
		cyc(1);
		`CHK(rdata, 32'h0000_0000, "rdata after read")
		// chop decode, and a mid-cycle change that must wait for the cycle end
		wr(CHOP_OFS, 32'h2);
		pulseMux();
		`CHK(chopSignal, 1'b1, "chop reversed")
		wr(CHOP_OFS, 32'h1);
		`CHK(chopSignal, 1'b1, "chop mid-cycle")
		pulseMux();
		`CHK(chopSignal, 1'b0, "chop positive")
		// two automatic cycles, an even count, keep the polarity balanced
		wr(CHOP_OFS, 32'h3);
		pulseMux();
		`CHK(chopSignal, 1'b1, "toggle 11 a")
		pulseMux();
		`CHK(chopSignal, 1'b0, "toggle 11 b")
		wr(CHOP_OFS, 32'h0);
		pulseMux();
		`CHK(chopSignal, 1'b1, "toggle 00")
		rd(STATUS_OFS, d);
		`CHK(d[CHOP_BIT], 1'b1, "chop status")
		// internal compensation: firmware writes to the word are refused
		wr(CTRL_OFS, 32'h1 << CE_EN_BIT);
		wr(LIN_COEFF_OFS, 32'd100);
		wr(QUAD_COEFF_OFS, 32'd256);
		wr(REF_TEMP_OFS, 32'h0100);
		wr(GAIN_ADJUST_WORD_OFS, 32'h1234);
		rd(GAIN_ADJUST_WORD_OFS, d);
		`CHK(d, 32'h0000_0000, "gain write refused")
		pulseMux();
		`CHK(gainAdjust, 32'(GAIN_EXP), "gain computed")
		wr(EXTERNAL_TEMP_SELECT_OFS, EXT_EXTERNAL);
		wr(GAIN_ADJUST_WORD_OFS, 32'h0000_cafe);
		pulseMux();
		`CHK(gainAdjust, 32'h0000_cafe, "gain external")
		// watchdog flag and engine words survive a supply drop, config does not
		@(posedge clk);
		watchdogOverflow <= 1'b1;
		@(posedge clk);
		watchdogOverflow <= 1'b0;
		cyc(1);
		`CHK(watchdogOverflowFlag, 1'b1, "watchdog set")
		@(posedge clk);
		supplySenseInput <= 1'b0;
		cyc(6);
		`CHK(processorReset_n, 1'b0, "supply drop")
		`CHK(ceEnable, 1'b0, "engine off in reset")
		powerUp();
		`CHK(watchdogOverflowFlag, 1'b1, "watchdog kept")
		rd(CTRL_OFS, d);
		`CHK(d, 32'h0000_0000, "ctrl cleared")
		rd(CHOP_OFS, d);
		`CHK(d, 32'h0000_0000, "chop cleared")
		rd(GAIN_ADJUST_WORD_OFS, d);
		`CHK(d, 32'h0000_cafe, "gain kept")
		wr(STATUS_OFS, 32'h1);
		rd(STATUS_OFS, d);
		`CHK(d[WDOG_BIT], 1'b0, "watchdog cleared")
		// the reset pin alone must also put the block into reset mode
		@(posedge clk);
		resetPin_n <= 1'b0;
		cyc(6);
		`CHK(processorReset_n, 1'b0, "reset pin low")
		`CHK(converterEnable, 1'b0, "activity stopped")
		conclude();
	end
endmodule // testbench
